// [inc/gcs_pkg.sv]
package gcs_pkg;
	// ****************************************************
	// access byte layout
	// ****************************************************
	localparam int ADDR_W = 7;
	localparam int RW_BIT = 7; // one marks a write, address stays plain
	localparam logic [7:0] WRITE_OFFSET = 8'h80; // write adds 0x80 on bit 7
	localparam int DATA_W = 32;

	// ****************************************************
	// register offsets
	// ****************************************************
	localparam logic [6:0] GLOBAL_CONFIG_ADDR = 7'h00;
	localparam logic [6:0] GLOBAL_FLAGS_ADDR = 7'h01;
	localparam logic [6:0] WRITE_TRANSFER_COUNT_ADDR = 7'h02;

	// ****************************************************
	// field positions and widths
	// ****************************************************
	localparam int CFG_W = 10;
	localparam int CFG_PWM_DIRECT = 0;
	localparam int CFG_EXT_CAP = 1;
	localparam int CFG_PAR_MODE = 2;
	localparam int CFG_TEST_MODE = 7;
	localparam logic [9:0] CFG_WMASK = 10'h387; // bits 3..6 stay zero
	localparam int FLG_W = 3;
	localparam int FLG_RESET = 0;
	localparam int FLG_DRV_ERR = 1;
	localparam int FLG_SUPPLY_LOW = 2;
	localparam int CNT_W = 8;

	// ****************************************************
	// values after reset
	// ****************************************************
	localparam logic [9:0] CFG_RESET = 10'h000;
	localparam logic [1:0] FLG_LATCH_RESET = 2'h1; // reset flag starts set
	localparam logic [7:0] CNT_RESET = 8'h00;
	localparam logic [7:0] CNT_STEP = 8'h01;
endpackage : gcs_pkg

// [rtl/gcs_regs.sv]
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - power-up clears registers except listed defaults
// - write address adds 0x80, read plain
// - written ones clear flags, zeros keep
// - config at 0x00, 10 bits, read/write
// - bit 0 bridge drive style, reset zero
// - bit 1 set omits switching delays
// - bit 2 mirrors bridge A onto B
// - bit 7 routes analog test to bridge_a_out1
// - flags at 0x01, three bits, W1C
// - bit 0 shows reset since last clear
// - driver error latches, clear refused while active
// - bit 2 follows live supply comparator
// - counter at 0x02, 8 bits, read-only
// - counter wraps 255 to 0, reads harmless
// - only own-address good-checksum writes count
// - access byte: top bit write, seven address
module gcs_regs
	import gcs_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// decoded datagram from the serial front end
	input wire logic accStb,
	input wire logic [7:0] accByte,
	input wire logic [DATA_W-1:0] accWdata,
	input wire logic accAddrOk,
	input wire logic accCrcOk,
	// read answer toward the reply sender
	output logic rdValid_q,
	output logic [DATA_W-1:0] rdData_q,
	// analog and protection inputs (asynchronous)
	input wire logic drvFault,
	input wire logic supplyLow,
	// bridge drive from the motor control logic
	input wire logic [1:0] bridgeAIn,
	input wire logic [1:0] bridgeBIn,
	input wire logic testSelDac,
	// configuration outcomes
	output logic pwmDirect_q,
	output logic switchDelayEn_q,
	output logic parMode_q,
	output logic bridgeATestEn_q,
	output logic bridgeATestDac_q,
	output logic [1:0] bridgeAOut_q,
	output logic [1:0] bridgeBOut_q
);

	// ****************************************************
	// access decode
	// ****************************************************

	// only datagrams for us with a good checksum count at all
	wire logic accGood;
	wire logic isWrite;
	wire logic [ADDR_W-1:0] accAddr;
	wire logic wrGood;
	wire logic rdGood;
	wire logic wrCfg;
	wire logic wrFlg;
	assign accGood = accStb & accAddrOk & accCrcOk;
	assign isWrite = accByte[RW_BIT];
	assign accAddr = accByte[ADDR_W-1:0];
	assign wrGood = accGood & isWrite;
	assign rdGood = accGood & ~isWrite;
	assign wrCfg = wrGood & (accAddr == GLOBAL_CONFIG_ADDR);
	assign wrFlg = wrGood & (accAddr == GLOBAL_FLAGS_ADDR);

	// ****************************************************
	// input synchronisers
	// ****************************************************

	// fault and comparator come from the analog side, so two stages
	logic [1:0] syncA_q;
	logic [1:0] syncB_q;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			syncA_q <= 2'h0;
			syncB_q <= 2'h0;
		end else begin
			syncA_q <= {supplyLow, drvFault};
			syncB_q <= syncA_q;
		end
	end
	wire logic faultSync;
	wire logic lowSync;
	assign faultSync = syncB_q[0];
	assign lowSync = syncB_q[1];

	// ****************************************************
	// global configuration
	// ****************************************************

	logic [CFG_W-1:0] cfg_q;
	wire logic [CFG_W-1:0] cfg_d;
	// reserved bits are masked on write, so they can never read back
	assign cfg_d = wrCfg ? (accWdata[CFG_W-1:0] & CFG_WMASK) : cfg_q;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_q <= CFG_RESET;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// ****************************************************
	// global flags
	// ****************************************************

	// reset flag and driver error are latched; supply low is live
	logic [1:0] flg_q;
	wire logic [1:0] flgClr;
	wire logic [1:0] flg_d;
	assign flgClr = wrFlg ? accWdata[1:0] : 2'h0;
	// a standing fault sets again each cycle, so its clear is refused
	assign flg_d = {faultSync | (flg_q[1] & ~flgClr[1]),
		flg_q[0] & ~flgClr[0]};

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			flg_q <= FLG_LATCH_RESET;
		end else begin
			flg_q <= flg_d;
		end
	end

	wire logic [FLG_W-1:0] flgRead;
	assign flgRead = {lowSync, flg_q};

	// ****************************************************
	// write transfer counter
	// ****************************************************

	// every good write counts, whichever register it hits
	logic [CNT_W-1:0] cnt_q;
	wire logic [CNT_W-1:0] cnt_d;
	assign cnt_d = wrGood ? cnt_q + CNT_STEP : cnt_q;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= CNT_RESET;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// ****************************************************
	// read answer
	// ****************************************************

	// unmapped addresses answer with zero rather than stale data
	logic [DATA_W-1:0] rdMux;
	always_comb begin
		rdMux = '0;
		case (accAddr)
			GLOBAL_CONFIG_ADDR: rdMux[CFG_W-1:0] = cfg_q;
			GLOBAL_FLAGS_ADDR: rdMux[FLG_W-1:0] = flgRead;
			WRITE_TRANSFER_COUNT_ADDR: rdMux[CNT_W-1:0] = cnt_q;
			default: rdMux = '0;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rdValid_q <= 1'b0;
			rdData_q <= '0;
		end else begin
			rdValid_q <= rdGood;
			rdData_q <= rdGood ? rdMux : rdData_q;
		end
	end

	// ****************************************************
	// configuration outcomes
	// ****************************************************

	// registered from the next value so outputs follow with cfg_q
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pwmDirect_q <= 1'b0;
			switchDelayEn_q <= 1'b1;
			parMode_q <= 1'b0;
			bridgeATestEn_q <= 1'b0;
		end else begin
			pwmDirect_q <= cfg_d[CFG_PWM_DIRECT];
			switchDelayEn_q <= ~cfg_d[CFG_EXT_CAP];
			parMode_q <= cfg_d[CFG_PAR_MODE];
			bridgeATestEn_q <= cfg_d[CFG_TEST_MODE];
		end
	end

	// bridge B copies A in parallel mode; one cycle of latency on both
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			bridgeAOut_q <= 2'h0;
			bridgeBOut_q <= 2'h0;
			bridgeATestDac_q <= 1'b0;
		end else begin
			bridgeAOut_q <= bridgeAIn;
			bridgeBOut_q <= cfg_q[CFG_PAR_MODE] ? bridgeAIn : bridgeBIn;
			bridgeATestDac_q <= testSelDac;
		end
	end

	// ****************************************************
	// assertions
	// ****************************************************

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	sequence sGoodWrite(logic [6:0] a);
		accStb && accAddrOk && accCrcOk && accByte == {1'b1, a};
	endsequence

	sequence sGoodRead;
		accStb && accAddrOk && accCrcOk && !accByte[RW_BIT];
	endsequence

	AST_CNT_INC: assert property (
		accStb && accAddrOk && accCrcOk && accByte[RW_BIT]
		|=> cnt_q == $past(cnt_q) + 8'h01)
		else $error("counter missed a good write");

	AST_CNT_BAD: assert property (
		accStb && !(accAddrOk && accCrcOk) |=> $stable(cnt_q))
		else $error("counter moved on a rejected datagram");

	AST_CNT_READ: assert property (
		sGoodRead |=> $stable(cnt_q))
		else $error("counter moved on a read");

	AST_CNT_WRAP: assert property (
		wrGood && cnt_q == 8'hff
		|=> cnt_q == 8'h00)
		else $error("counter did not wrap to zero");

	AST_CFG_WR: assert property (
		sGoodWrite(GLOBAL_CONFIG_ADDR)
		|=> cfg_q == ($past(accWdata[9:0]) & CFG_WMASK)
		&& pwmDirect_q == $past(accWdata[CFG_PWM_DIRECT])
		&& parMode_q == $past(accWdata[CFG_PAR_MODE]))
		else $error("config write not stored");

	AST_RSV_ZERO: assert property (
		cfg_q[6:3] == 4'h0)
		else $error("reserved config bits not zero");

	AST_EXTCAP: assert property (
		##1 switchDelayEn_q == !cfg_q[CFG_EXT_CAP])
		else $error("switch delay enable wrong");

	AST_W1C_RESET: assert property (
		sGoodWrite(GLOBAL_FLAGS_ADDR) ##0 accWdata[0] |=> !flg_q[0])
		else $error("reset flag not cleared by one");

	AST_W0_KEEP: assert property (
		sGoodWrite(GLOBAL_FLAGS_ADDR) ##0 !accWdata[0] && flg_q[0]
		|=> flg_q[0])
		else $error("reset flag cleared by zero");

	AST_DRV_HOLD: assert property (
		faultSync |=> flg_q[FLG_DRV_ERR])
		else $error("driver error clear not refused");

	AST_SUPPLY: assert property (
		$rose(supplyLow) ##1 supplyLow |=> ##1 flgRead[FLG_SUPPLY_LOW])
		else $error("supply low not followed");

	AST_PAR: assert property (
		cfg_q[CFG_PAR_MODE] ##1 cfg_q[CFG_PAR_MODE]
		|-> bridgeBOut_q == bridgeAOut_q)
		else $error("bridges differ in parallel mode");

	AST_RD_ANS: assert property (
		sGoodRead ##0 accByte[6:0] == WRITE_TRANSFER_COUNT_ADDR
		|=> rdValid_q && rdData_q == {24'h0, $past(cnt_q)})
		else $error("read answer wrong");

	AST_RD_CFG: assert property (
		sGoodRead ##0 accByte[6:0] == GLOBAL_CONFIG_ADDR
		|=> rdValid_q && rdData_q == {22'h0, $past(cfg_q)})
		else $error("config read answer wrong");

	// a rejected datagram must not leak into the stored configuration
	AST_CFG_BAD: assert property (
		accStb && !(accAddrOk && accCrcOk) |=> $stable(cfg_q))
		else $error("config moved on a rejected datagram");

	AST_CNT_RO: assert property (
		sGoodWrite(WRITE_TRANSFER_COUNT_ADDR)
		|=> cnt_q == $past(cnt_q) + CNT_STEP)
		else $error("counter took written data");

	AST_EXTCAP_WR: assert property (
		sGoodWrite(GLOBAL_CONFIG_ADDR)
		|=> switchDelayEn_q == !$past(accWdata[CFG_EXT_CAP]))
		else $error("switch delay enable missed a write");

	// the supply flag is live, so it must drop again with the comparator
	AST_SUPPLY_FALL: assert property (
		$fell(supplyLow) ##1 !supplyLow |=> ##1 !flgRead[FLG_SUPPLY_LOW])
		else $error("supply low flag latched");

endmodule : gcs_regs

`default_nettype wire

// [testbench/gcs_host_model.sv]
`timescale 1ns/100ps
`default_nettype none

// ****************************************************
// host side of the datagram link, behavioural
// ****************************************************
module gcs_host_model
	import gcs_pkg::*;
(
	// clock
	input wire logic core_clk,
	// decoded datagram toward the register block
	output logic accStb,
	output logic [7:0] accByte,
	output logic [DATA_W-1:0] accWdata,
	output logic accAddrOk,
	output logic accCrcOk
);
	// idle with no datagram pending
	initial begin
		accStb = 1'b0;
		accByte = 8'h00;
		accWdata = 32'h0;
		accAddrOk = 1'b0;
		accCrcOk = 1'b0;
	end

	// caller sets config bit 0 before any driver enable
	// caller keeps bits 3..6 zero unless probing readback
	// one datagram, held over the taking edge, then scrambled
	task automatic send(input logic wr, input logic [6:0] addr,
		input logic [DATA_W-1:0] d, input logic aOk, input logic cOk);
		@(posedge core_clk);
		#10;
		accStb = 1'b1;
		accByte = wr ? (WRITE_OFFSET | {1'b0, addr}) : {1'b0, addr};
		accWdata = d;
		accAddrOk = aOk;
		accCrcOk = cOk;
		@(posedge core_clk);
		#10;
		accStb = 1'b0;
		accByte = ~accByte; // stale qualifiers never look valid
		accWdata = ~accWdata;
		accAddrOk = ~accAddrOk;
		accCrcOk = ~accCrcOk;
	endtask : send
endmodule : gcs_host_model

`default_nettype wire

// [testbench/gcs_regs_tb.sv]
`timescale 1ns/100ps
`default_nettype none

module gcs_regs_tb;
	import gcs_pkg::*;
	// ****************************************************
	// signals and bookkeeping
	// ****************************************************
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic drvFault = 1'b0;
	logic supplyLow = 1'b0;
	logic [1:0] bridgeAIn = 2'h0;
	logic [1:0] bridgeBIn = 2'h0;
	logic testSelDac = 1'b0;
	wire logic accStb, accAddrOk, accCrcOk, rdValid_q;
	wire logic [7:0] accByte;
	wire logic [DATA_W-1:0] accWdata, rdData_q;
	wire logic pwmDirect_q, switchDelayEn_q, parMode_q;
	wire logic bridgeATestEn_q, bridgeATestDac_q;
	wire logic [1:0] bridgeAOut_q, bridgeBOut_q;
	int n_fail = 0;
	int n_checks = 0;
	int seed = 32'h64668d79;
	logic [31:0] expQ[$];
	logic [7:0] cnt = 8'h00;
	logic [31:0] d;
	logic [9:0] lastCfg;
	logic [4:0] ab;

	always #50 core_clk = ~core_clk; // 10 MHz

	gcs_host_model host (.core_clk(core_clk), .accStb(accStb),
		.accByte(accByte), .accWdata(accWdata), .accAddrOk(accAddrOk),
		.accCrcOk(accCrcOk));

	gcs_regs DUT (.core_clk(core_clk), .rstn(rstn), .accStb(accStb),
		.accByte(accByte), .accWdata(accWdata), .accAddrOk(accAddrOk),
		.accCrcOk(accCrcOk), .rdValid_q(rdValid_q), .rdData_q(rdData_q),
		.drvFault(drvFault), .supplyLow(supplyLow), .bridgeAIn(bridgeAIn),
		.bridgeBIn(bridgeBIn), .testSelDac(testSelDac),
		.pwmDirect_q(pwmDirect_q), .switchDelayEn_q(switchDelayEn_q),
		.parMode_q(parMode_q), .bridgeATestEn_q(bridgeATestEn_q),
		.bridgeATestDac_q(bridgeATestDac_q), .bridgeAOut_q(bridgeAOut_q),
		.bridgeBOut_q(bridgeBOut_q));

	// ****************************************************
	// compare, access helpers, verdict
	// ****************************************************
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("Error at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : chk

	task automatic rd(input logic [6:0] a, input logic [31:0] e);
		expQ.push_back(e);
		host.send(1'b0, a, 32'h0, 1'b1, 1'b1);
	endtask : rd

	task automatic wr(input logic [6:0] a, input logic [31:0] v);
		host.send(1'b1, a, v, 1'b1, 1'b1);
		cnt = cnt + 8'h01;
	endtask : wr

	task automatic end_of_test;
		if (n_fail == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test

	// answers matched in issue order, sampled mid-cycle off the launch edge
	always @(negedge core_clk) begin
		if (rdValid_q === 1'b1) begin
			if (expQ.size() == 0) chk(32'h1, 32'h0);
			else chk(rdData_q, expQ.pop_front());
		end
	end

	// a hung handshake ends the run; about 590 cycles are expected
	initial begin
		#2000000;
		n_fail++;
		end_of_test();
	end

	// ****************************************************
	// scenarios
	// ****************************************************
	initial begin
		repeat (4) @(posedge core_clk);
		#10;
		rstn = 1'b1;
		rd(GLOBAL_CONFIG_ADDR, 32'h0);
		rd(GLOBAL_FLAGS_ADDR, 32'h1);
		rd(WRITE_TRANSFER_COUNT_ADDR, 32'h0);
		chk(switchDelayEn_q, 1'b1);
		for (int i = 0; i < 4; i++) begin
			d = $random(seed);
			d[2:0] = {i[0], i[1], 1'b1};
			lastCfg = d[9:0] & CFG_WMASK;
			wr(GLOBAL_CONFIG_ADDR, d);
			rd(GLOBAL_CONFIG_ADDR, {22'h0, lastCfg});
			chk(pwmDirect_q, d[0]);
			chk(switchDelayEn_q, !d[1]);
			chk(parMode_q, d[2]);
			chk(bridgeATestEn_q, d[7]);
			ab = $random(seed);
			{testSelDac, bridgeBIn, bridgeAIn} = ab;
			@(posedge core_clk);
			#10;
			chk(bridgeAOut_q, ab[1:0]);
			chk(bridgeBOut_q, d[2] ? ab[1:0] : ab[3:2]);
			chk(bridgeATestDac_q, ab[4]);
		end
		wr(GLOBAL_FLAGS_ADDR, 32'h6);
		rd(GLOBAL_FLAGS_ADDR, 32'h1);
		wr(GLOBAL_FLAGS_ADDR, 32'h1);
		rd(GLOBAL_FLAGS_ADDR, 32'h0);
		drvFault = 1'b1;
		supplyLow = 1'b1;
		repeat (5) @(posedge core_clk);
		rd(GLOBAL_FLAGS_ADDR, 32'h6);
		wr(GLOBAL_FLAGS_ADDR, 32'h2);
		rd(GLOBAL_FLAGS_ADDR, 32'h6);
		drvFault = 1'b0;
		supplyLow = 1'b0;
		repeat (5) @(posedge core_clk);
		rd(GLOBAL_FLAGS_ADDR, 32'h2);
		wr(GLOBAL_FLAGS_ADDR, 32'h2);
		rd(GLOBAL_FLAGS_ADDR, 32'h0);
		rd(WRITE_TRANSFER_COUNT_ADDR, {24'h0, cnt});
		host.send(1'b1, GLOBAL_CONFIG_ADDR, 32'h3ff, 1'b0, 1'b1);
		host.send(1'b1, GLOBAL_CONFIG_ADDR, 32'h3ff, 1'b1, 1'b0);
		rd(GLOBAL_CONFIG_ADDR, {22'h0, lastCfg});
		rd(WRITE_TRANSFER_COUNT_ADDR, {24'h0, cnt});
		wr(WRITE_TRANSFER_COUNT_ADDR, 32'h55);
		rd(WRITE_TRANSFER_COUNT_ADDR, {24'h0, cnt});
		rd(7'h05, 32'h0);
		while (cnt !== 8'hff) wr(7'h05, $random(seed));
		rd(WRITE_TRANSFER_COUNT_ADDR, 32'hff);
		wr(7'h05, 32'h0);
		rd(WRITE_TRANSFER_COUNT_ADDR, 32'h0);
		// let the last answer be seen before reset clears it
		@(posedge core_clk);
		#10;
		// second reset in mid-run brings defaults back
		rstn = 1'b0;
		repeat (2) @(posedge core_clk);
		#10;
		rstn = 1'b1;
		rd(GLOBAL_CONFIG_ADDR, 32'h0);
		rd(GLOBAL_FLAGS_ADDR, 32'h1);
		rd(WRITE_TRANSFER_COUNT_ADDR, 32'h0);
		chk(switchDelayEn_q, 1'b1);
		repeat (3) @(posedge core_clk);
		chk(expQ.size(), 32'h0);
		end_of_test();
	end
endmodule : gcs_regs_tb

`default_nettype wire
